// [rtl/dfd_top.sv]
// module: dataway function decoder for a two-channel converter station
// Notes on behaviour
// RULE1 - every function and sub-address bit is compared; unknown pairs do nothing.
// RULE2 - X is raised for exactly the implemented function and sub-address pairs.
// RULE3 - the five function bits give 32 codes and the sub-address picks within the station.
// RULE4 - F0 and F2 at A0/A1 return that channel's result, F2 also starts it, Q is its busy.
// RULE5 - F25 starts channel 1 at A0, channel 2 at A1, both at A2, Q is busy or their OR.
// RULE6 - F2 and F25 start nothing in a cycle whose Q answer is 0.
// RULE7 - F8 tests LAM, F24 clears and F26 sets the LAM enable, at A0 and at A15.
// RULE8 - the controller gives S1 then S2, each 200 ns, in every dataway cycle.
// RULE9 - Z returns the dataway state, LAM enable and pending completions included, to its initial state; bus registers are kept.
// RULE10 - Q serves as the condition answer, mainly busy or LAM state.
// RULE11 - F27 at A0/A1 moves no data and answers the channel's busy on Q.
// RULE12 - the LAM line is high only while a completion is pending and LAM is enabled.
`timescale 1ns/1ps
`default_nettype none
module dfd_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic dw_n_i,
   input wire logic [4:0] dw_f_i,
   input wire logic [3:0] dw_a_i,
   input wire logic dw_s1_i,
   input wire logic dw_s2_i,
   input wire logic dw_z_i,
   output logic [23:0] dw_r_o,
   output logic dw_x_o,
   output logic dw_q_o,
   output logic dw_lam_o,
   input wire logic [1:0] adc_busy_i,
   input wire logic [1:0] adc_done_i,
   input wire logic [11:0] adc_res0_i,
   input wire logic [11:0] adc_res1_i,
   output logic [1:0] adc_start_o
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      dfd_pkg::dw_state_type st;
      logic [7:0] cnt;
      dfd_pkg::dw_cmd_type cmd;
      dfd_pkg::dw_dec_type dec;
      logic x;
      logic q;
      logic [23:0] r;
      logic [1:0] start;
      logic lam_en;
      logic [1:0] pend;
      logic offline;
      logic [3:0] irq_st;
      logic [3:0] irq_en;
      logic ack;
      logic [31:0] dat;
      logic s1d;
      logic s2d;
      logic zd;
   } dfd_regs_type;

   dfd_regs_type st;
   dfd_regs_type next_st;

   // ****************************************
   // pin synchronisers and decode
   // ****************************************
   logic [12:0] pin_raw;
   logic [12:0] pin_syn;
   dfd_pkg::dw_cmd_type cmd_now;
   dfd_pkg::dw_dec_type dec_now;
   logic s1;
   logic s2;
   logic z;
   logic s1_rise;
   logic s2_rise;
   logic z_rise;
   logic wb_go;
   logic [3:0] ev;
   logic [3:0] clr;

   assign pin_raw = {dw_n_i, dw_f_i, dw_a_i, dw_s1_i, dw_s2_i, dw_z_i};

   dfd_sync #(
      .W(13)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pin_raw),
      .q_o(pin_syn)
   );

   assign cmd_now = pin_syn[12:3];
   assign s1 = pin_syn[2];
   assign s2 = pin_syn[1];
   assign z = pin_syn[0];
   // strobes are used only through their rising edges [RULE8]
   assign s1_rise = s1 & ~st.s1d;
   assign s2_rise = s2 & ~st.s2d;
   assign z_rise = z & ~st.zd;

   dfd_decode u_dec (
      .cmd_i(cmd_now),
      .busy_i(adc_busy_i),
      .lam_i(dw_lam_o),
      .dec_o(dec_now)
   );

   // ****************************************
   // dataway sequencing and bus slave
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.start = 2'b00;
      next_st.s1d = s1;
      next_st.s2d = s2;
      next_st.zd = z;
      ev = 4'h0;
      clr = 4'h0;
      unique case (st.st)
         dfd_pkg::DW_IDLE: begin
            // an offline station accepts no dataway cycle, but Z still resets it
            if (s1_rise && cmd_now.n && !st.offline) begin
               next_st.cmd = cmd_now;
               next_st.dec = dec_now;
               next_st.x = dec_now.hit; // [RULE2]
               next_st.q = dec_now.q; // [RULE10]
               next_st.cnt = 8'h00;
               next_st.r = 24'h000000;
               if (dec_now.rd) begin
                  next_st.r = {12'h000, dec_now.rch ? adc_res1_i : adc_res0_i}; // [RULE4]
               end
               ev[dfd_pkg::IRQ_ACC] = dec_now.hit;
               ev[dfd_pkg::IRQ_REJ] = ~dec_now.hit;
               next_st.st = dfd_pkg::DW_S1;
            end
         end
         dfd_pkg::DW_S1: begin
            if (s2_rise) begin
               // actions only for a pair that was accepted [RULE1]
               if (st.x) begin
                  next_st.start = st.dec.start; // [RULE5] [RULE6]
                  if (st.dec.en_set) begin
                     next_st.lam_en = 1'b1; // [RULE7]
                  end
                  if (st.dec.en_clr) begin
                     next_st.lam_en = 1'b0; // [RULE7]
                  end
                  if (st.dec.rd) begin
                     next_st.pend[st.dec.rch] = 1'b0;
                  end
                  ev[dfd_pkg::IRQ_CONV] = |st.dec.start;
               end
               next_st.cnt = 8'h00;
               next_st.st = dfd_pkg::DW_S2;
            end else if (st.cnt == dfd_pkg::WAIT_CYC) begin
               // a lost S2 must not leave X and Q on the backplane
               next_st.x = 1'b0;
               next_st.q = 1'b0;
               next_st.r = 24'h000000;
               next_st.st = dfd_pkg::DW_IDLE;
            end else begin
               next_st.cnt = st.cnt + 8'h01;
            end
         end
         dfd_pkg::DW_S2: begin
            if (!cmd_now.n || st.cnt == dfd_pkg::WAIT_CYC) begin
               next_st.x = 1'b0;
               next_st.q = 1'b0;
               next_st.r = 24'h000000;
               next_st.st = dfd_pkg::DW_IDLE;
            end else begin
               next_st.cnt = st.cnt + 8'h01;
            end
         end
      endcase
      // a completion in the same cycle as a read clear is kept [RULE12]
      next_st.pend = next_st.pend | adc_done_i;
      if (z_rise) begin
         // general reset of the dataway state; the last command and interrupt status are kept [RULE9]
         next_st.st = dfd_pkg::DW_IDLE;
         next_st.lam_en = 1'b0;
         next_st.pend = 2'b00;
         next_st.x = 1'b0;
         next_st.q = 1'b0;
         next_st.r = 24'h000000;
         next_st.start = 2'b00;
         ev[dfd_pkg::IRQ_Z] = 1'b1;
      end
      // single-cycle classic slave; ack is never given twice in a row
      wb_go = wb_cyc_i & wb_stb_i & ~st.ack;
      next_st.ack = wb_go;
      if (wb_go && wb_we_i && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            dfd_pkg::REG_CTRL: next_st.offline = wb_dat_i[dfd_pkg::CTRL_OFFLINE];
            dfd_pkg::REG_IRQ_EN: next_st.irq_en = wb_dat_i[3:0];
            dfd_pkg::REG_IRQ_CLR: clr = wb_dat_i[3:0];
            default: begin
            end
         endcase
      end
      if (wb_go) begin
         next_st.dat = 32'h00000000;
         unique case (wb_adr_i)
            dfd_pkg::REG_CTRL: next_st.dat[0] = st.offline;
            dfd_pkg::REG_STAT: begin
               next_st.dat[7:0] = {st.q, st.x, adc_busy_i, st.pend, dw_lam_o, st.lam_en};
            end
            dfd_pkg::REG_IRQ_STAT: next_st.dat[3:0] = st.irq_st;
            dfd_pkg::REG_IRQ_EN: next_st.dat[3:0] = st.irq_en;
            dfd_pkg::REG_LAST: next_st.dat[9:0] = st.cmd;
            default: begin
            end
         endcase
      end
      // a new event beats a clear written in the same cycle
      next_st.irq_st = (st.irq_st & ~clr) | ev;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.offline <= dfd_pkg::CTRL_RST;
         st.irq_en <= dfd_pkg::IRQ_EN_RST;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign wb_dat_o = st.dat;
   assign wb_ack_o = st.ack;
   assign irq_o = |(st.irq_st & st.irq_en);
   assign dw_r_o = st.r;
   assign dw_x_o = st.x;
   assign dw_q_o = st.q;
   assign dw_lam_o = st.lam_en & |st.pend; // [RULE12]
   assign adc_start_o = st.start;

   // ****************************************
   // assertions
   // ****************************************
   default clocking dfd_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic acc_now;
   assign acc_now = (st.st == dfd_pkg::DW_IDLE) && s1_rise && cmd_now.n && !st.offline
      && !z_rise;

   a_x_on_hit: assert property (acc_now |=> dw_x_o == $past(dec_now.hit)) // [RULE2]
      else $error("X does not follow the decode of the accepted pair");

   a_no_act_unimpl: assert property ((adc_start_o != 2'b00) |-> st.dec.hit && st.x) // [RULE1]
      else $error("conversion started for a pair that is not implemented");

   a_start_needs_q: assert property ((adc_start_o != 2'b00) |-> dw_q_o) // [RULE6]
      else $error("conversion started while Q answers 0");

   a_read_result: assert property (
      $rose(dw_x_o) && st.dec.rd && !st.dec.rch |-> dw_r_o == {12'h000, $past(adc_res0_i)}
   ) // [RULE4]
      else $error("channel 1 result not presented on read");

   a_both_start: assert property (
      adc_start_o == 2'b11 |-> st.cmd.a == dfd_pkg::A_BOTH && st.cmd.f == dfd_pkg::F_CONV
   ) // [RULE5]
      else $error("both channels started outside F25 A2");

   a_lam_q_one: assert property (
      dw_x_o && (st.cmd.f == dfd_pkg::F_CLR_EN || st.cmd.f == dfd_pkg::F_SET_EN) |-> dw_q_o
   ) // [RULE7]
      else $error("LAM enable function did not answer Q=1");

   a_set_en_done: assert property (
      st.st == dfd_pkg::DW_S1 && s2_rise && st.x && st.dec.en_set && !z_rise |=> st.lam_en
   ) // [RULE7]
      else $error("set LAM enable had no effect");

   a_z_clears: assert property (z_rise |=> !st.lam_en && !dw_lam_o && !dw_x_o) // [RULE9]
      else $error("Z did not clear the station");

   a_lam_gate: assert property (
      $rose(dw_lam_o) |-> $past(adc_done_i != 2'b00) || $past(next_st.lam_en && !st.lam_en)
   ) // [RULE12]
      else $error("LAM raised with no completion or enable");

   a_test_busy: assert property (
      $rose(dw_x_o) && st.cmd.f == dfd_pkg::F_TEST_BUSY && st.cmd.a == dfd_pkg::A_CH2
      |-> dw_q_o == $past(adc_busy_i[1]) && dw_r_o == 24'h000000
   ) // [RULE11]
      else $error("F27 A1 gave wrong Q or moved data");

   a_test_lam: assert property (
      $rose(dw_x_o) && st.cmd.f == dfd_pkg::F_TEST_LAM |-> dw_q_o == $past(dw_lam_o)
   ) // [RULE10]
      else $error("F8 did not report the LAM state on Q");

   a_read_ch2: assert property (
      $rose(dw_x_o) && st.dec.rd && st.dec.rch |-> dw_r_o == {12'h000, $past(adc_res1_i)}
   ) // [RULE4]
      else $error("channel 2 result not presented on read");

   a_clr_en_done: assert property (
      st.st == dfd_pkg::DW_S1 && s2_rise && st.x && st.dec.en_clr |=> !st.lam_en
   ) // [RULE7]
      else $error("clear LAM enable had no effect");

   a_q_needs_x: assert property (dw_q_o |-> dw_x_o) // [RULE10]
      else $error("Q answered for a pair that was not accepted");

   a_start_pulse: assert property ((adc_start_o != 2'b00) |=> adc_start_o == 2'b00) // [RULE5]
      else $error("start pulse longer than one cycle");

   // an offline station must never answer the dataway
   a_offline_quiet: assert property (st.offline && st.st == dfd_pkg::DW_IDLE |=> !dw_x_o)
      else $error("offline station accepted a dataway cycle");

   a_x_drops_n: assert property (
      st.st == dfd_pkg::DW_S2 && !cmd_now.n |=> !dw_x_o && !dw_q_o
   ) // [RULE2]
      else $error("X or Q still standing after N was released");

   // a held strobe must not be acknowledged in two consecutive cycles
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus acknowledge lasted more than one cycle");

   c_conv_both: cover property (adc_start_o == 2'b11);
   c_lam_raised: cover property ($rose(dw_lam_o));
   c_read_ch2: cover property ($rose(dw_x_o) && st.dec.rd && st.dec.rch);
   c_z_reset: cover property (z_rise && st.lam_en);
   c_lam_alt: cover property ($rose(dw_x_o) && st.cmd.a == dfd_pkg::A_LAM_ALT);

endmodule
`default_nettype wire

// [include/dfd_pkg.sv]
// package: constants and carrier types of the dataway function decoder
package dfd_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS = 10;
   localparam int STROBE_NS = 200;
   localparam int STROBE_CYC = STROBE_NS / CLK_NS;
   // a dataway cycle that stalls longer than this is abandoned
   localparam logic [7:0] WAIT_CYC = 8'(8 * STROBE_CYC);

   // ****************************************
   // function codes and sub-addresses
   // ****************************************
   localparam logic [4:0] F_READ = 5'h00;
   localparam logic [4:0] F_READ_CONV = 5'h02;
   localparam logic [4:0] F_TEST_LAM = 5'h08;
   localparam logic [4:0] F_CLR_EN = 5'h18;
   localparam logic [4:0] F_CONV = 5'h19;
   localparam logic [4:0] F_SET_EN = 5'h1A;
   localparam logic [4:0] F_TEST_BUSY = 5'h1B;
   localparam logic [3:0] A_CH1 = 4'h0;
   localparam logic [3:0] A_CH2 = 4'h1;
   localparam logic [3:0] A_BOTH = 4'h2;
   localparam logic [3:0] A_LAM_ALT = 4'hF;

   // ****************************************
   // register map and fields
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_EN = 8'h0C;
   localparam logic [7:0] REG_IRQ_CLR = 8'h10;
   localparam logic [7:0] REG_LAST = 8'h14;
   localparam int CTRL_OFFLINE = 0;
   localparam logic CTRL_RST = 1'b0;
   localparam logic [3:0] IRQ_EN_RST = 4'h0;
   localparam int IRQ_W = 4;
   localparam int IRQ_ACC = 0;
   localparam int IRQ_REJ = 1;
   localparam int IRQ_CONV = 2;
   localparam int IRQ_Z = 3;

   // ****************************************
   // carrier types
   // ****************************************
   typedef struct packed {
      logic n;
      logic [4:0] f;
      logic [3:0] a;
   } dw_cmd_type;

   typedef struct packed {
      logic hit;
      logic q;
      logic rd;
      logic rch;
      logic [1:0] start;
      logic en_set;
      logic en_clr;
   } dw_dec_type;

   typedef enum logic [1:0] {
      DW_IDLE,
      DW_S1,
      DW_S2
   } dw_state_type;

endpackage

// [rtl/dfd_sync.sv]
// module: two-stage synchroniser for the dataway pins
`timescale 1ns/1ps
`default_nettype none
module dfd_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } dfd_sync_type;

   dfd_sync_type st;
   dfd_sync_type next_st;

   // the first stage feeds the second stage only
   always_comb begin
      next_st.meta = d_i;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.stable;
endmodule
`default_nettype wire

// [rtl/dfd_decode.sv]
// module: function and sub-address decode with condition response
`timescale 1ns/1ps
`default_nettype none
module dfd_decode (
   input wire dfd_pkg::dw_cmd_type cmd_i,
   input wire logic [1:0] busy_i,
   input wire logic lam_i,
   output var dfd_pkg::dw_dec_type dec_o
);
   always_comb begin
      logic [1:0] sel;
      logic ch;
      logic lam_a;
      sel = cmd_i.a[0] ? 2'b10 : 2'b01;
      // full 4-bit compare, so A(3)..A(14) never alias a channel [RULE3]
      ch = (cmd_i.a == dfd_pkg::A_CH1) || (cmd_i.a == dfd_pkg::A_CH2);
      lam_a = (cmd_i.a == dfd_pkg::A_CH1) || (cmd_i.a == dfd_pkg::A_LAM_ALT);
      dec_o = '0;
      // all five function bits compared; other codes fall through [RULE1]
      case (cmd_i.f)
         dfd_pkg::F_READ, dfd_pkg::F_READ_CONV: begin
            if (ch) begin
               dec_o.hit = 1'b1;
               dec_o.rd = 1'b1;
               dec_o.rch = cmd_i.a[0];
               dec_o.q = |(busy_i & sel); // [RULE4]
               if (cmd_i.f == dfd_pkg::F_READ_CONV) begin
                  dec_o.start = sel;
               end
            end
         end
         dfd_pkg::F_TEST_LAM: begin
            dec_o.hit = lam_a;
            dec_o.q = lam_a & lam_i; // [RULE7] [RULE10]
         end
         dfd_pkg::F_CLR_EN, dfd_pkg::F_SET_EN: begin
            dec_o.hit = lam_a;
            dec_o.q = lam_a; // [RULE7]
            dec_o.en_clr = lam_a & (cmd_i.f == dfd_pkg::F_CLR_EN);
            dec_o.en_set = lam_a & (cmd_i.f == dfd_pkg::F_SET_EN);
         end
         dfd_pkg::F_CONV: begin
            if (ch) begin
               dec_o.hit = 1'b1;
               dec_o.q = |(busy_i & sel); // [RULE5]
               dec_o.start = sel;
            end else if (cmd_i.a == dfd_pkg::A_BOTH) begin
               dec_o.hit = 1'b1;
               dec_o.q = |busy_i; // [RULE5]
               dec_o.start = 2'b11;
            end
         end
         dfd_pkg::F_TEST_BUSY: begin
            dec_o.hit = ch;
            dec_o.q = ch & |(busy_i & sel); // [RULE11]
         end
         default: begin
         end
      endcase
      // a start is withheld whenever the cycle answers Q=0 [RULE6]
      if (!dec_o.q) begin
         dec_o.start = 2'b00;
      end
   end
endmodule
`default_nettype wire

// [tb/dfd_ctrl_model.sv]
// file: crate controller model that drives the station's dataway pins
`timescale 1ns/1ps
`default_nettype none
module dfd_ctrl_model (
   input wire logic clk_i,
   input wire logic dw_x_i,
   input wire logic dw_q_i,
   input wire logic [23:0] dw_r_i,
   output logic dw_n_o,
   output logic [4:0] dw_f_o,
   output logic [3:0] dw_a_o,
   output logic dw_s1_o,
   output logic dw_s2_o,
   output logic dw_z_o
);
   initial begin
      dw_n_o = 1'b0;
      dw_f_o = 5'h00;
      dw_a_o = 4'h0;
      dw_s1_o = 1'b0;
      dw_s2_o = 1'b0;
      dw_z_o = 1'b0;
   end

   // one dataway cycle; gap stretches the pause between the strobes
   task automatic run(input logic [4:0] f, input logic [3:0] a, input int gap,
                      output logic x, output logic q, output logic [23:0] r);
      @(posedge clk_i);
      dw_n_o <= 1'b1;
      dw_f_o <= f;
      dw_a_o <= a;
      repeat (4) @(posedge clk_i);
      dw_s1_o <= 1'b1;
      repeat (dfd_pkg::STROBE_CYC) @(posedge clk_i);
      dw_s1_o <= 1'b0;
      repeat (gap) @(posedge clk_i);
      dw_s2_o <= 1'b1;
      repeat (dfd_pkg::STROBE_CYC) @(posedge clk_i);
      x = dw_x_i;
      q = dw_q_i;
      r = dw_r_i;
      dw_s2_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      dw_n_o <= 1'b0;
      // released lines show the inverse so stale values cannot pass
      dw_f_o <= ~f;
      dw_a_o <= ~a;
      repeat (6) @(posedge clk_i);
   endtask

   task automatic pulse_z();
      @(posedge clk_i);
      dw_z_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      dw_z_o <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// file: self-checking bench for the dataway function decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, irq_o, dw_x_o, dw_q_o, dw_lam_o;
   logic dw_n_i, dw_s1_i, dw_s2_i, dw_z_i;
   logic [4:0] dw_f_i;
   logic [3:0] dw_a_i;
   logic [23:0] dw_r_o;
   logic [1:0] adc_busy_i = 2'h0, adc_done_i = 2'h0, adc_start_o;
   logic [11:0] adc_res0_i = 12'h000, adc_res1_i = 12'h000;
   int n_errors = 0, n_checks = 0, cycles = 0;
   logic [31:0] seed = 32'h00000036;
   logic lam_en = 1'b0, clr = 1'b0;
   logic [1:0] pend = 2'h0, seen = 2'h0;
   logic [3:0] irq_m = 4'h0;

   always #5 clk_i = ~clk_i;

   dfd_top u_dfd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .dw_n_i(dw_n_i),
      .dw_f_i(dw_f_i), .dw_a_i(dw_a_i), .dw_s1_i(dw_s1_i), .dw_s2_i(dw_s2_i),
      .dw_z_i(dw_z_i), .dw_r_o(dw_r_o), .dw_x_o(dw_x_o), .dw_q_o(dw_q_o),
      .dw_lam_o(dw_lam_o), .adc_busy_i(adc_busy_i), .adc_done_i(adc_done_i),
      .adc_res0_i(adc_res0_i), .adc_res1_i(adc_res1_i), .adc_start_o(adc_start_o));

   dfd_ctrl_model u_dfd_ctrl_model (.clk_i(clk_i), .dw_x_i(dw_x_o), .dw_q_i(dw_q_o),
      .dw_r_i(dw_r_o), .dw_n_o(dw_n_i), .dw_f_o(dw_f_i), .dw_a_o(dw_a_i),
      .dw_s1_o(dw_s1_i), .dw_s2_o(dw_s2_i), .dw_z_o(dw_z_i));

   // ****************************************
   // helpers
   // ****************************************
   // start pulses last one cycle, so they are gathered rather than sampled
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      seen <= clr ? 2'h0 : (seen | adc_start_o);
      if (cycles > 90000) begin
         n_errors++;
         wrap_up();
      end
   end

   function automatic logic [31:0] xs_next();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= ad;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (k == 50) n_errors++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] q;
      wb(1'b0, ad, 32'h00000000, q);
      chk(q & m, exp);
   endtask

   // one dataway command against the bench's own model of the station
   task automatic do_cmd(input logic [4:0] f, input logic [3:0] a, input logic off);
      logic x, q, ex, eq, lam;
      logic [23:0] r, er;
      logic [1:0] es, d, b;
      logic [31:0] rv, rr;
      rv = xs_next();
      rr = xs_next();
      b = rv[9:8];
      d = (rv[7:4] == 4'h0) ? rv[1:0] : 2'h0;
      @(posedge clk_i);
      adc_busy_i <= b;
      adc_res0_i <= rr[11:0];
      adc_res1_i <= rr[27:16];
      adc_done_i <= d;
      clr <= 1'b1;
      @(posedge clk_i);
      adc_done_i <= 2'h0;
      clr <= 1'b0;
      pend = pend | d;
      lam = lam_en & (|pend);
      ex = 1'b0;
      eq = 1'b0;
      er = 24'h000000;
      es = 2'h0;
      if (!off) begin
         case (f)
            dfd_pkg::F_READ, dfd_pkg::F_READ_CONV: if (a < 4'h2) begin
               ex = 1'b1;
               eq = b[a[0]];
               er = {12'h000, a[0] ? rr[27:16] : rr[11:0]};
               if (f == dfd_pkg::F_READ_CONV && eq) es[a[0]] = 1'b1;
            end
            dfd_pkg::F_TEST_LAM: if (a == dfd_pkg::A_CH1 || a == dfd_pkg::A_LAM_ALT) begin
               ex = 1'b1;
               eq = lam;
            end
            dfd_pkg::F_CLR_EN, dfd_pkg::F_SET_EN: begin
               ex = (a == dfd_pkg::A_CH1 || a == dfd_pkg::A_LAM_ALT);
               eq = ex;
            end
            dfd_pkg::F_CONV: if (a < 4'h3) begin
               ex = 1'b1;
               eq = (a == dfd_pkg::A_BOTH) ? |b : b[a[0]];
               if (eq) es = (a == dfd_pkg::A_BOTH) ? 2'h3 : (2'h1 << a[0]);
            end
            dfd_pkg::F_TEST_BUSY: if (a < 4'h2) begin
               ex = 1'b1;
               eq = b[a[0]];
            end
            default: ;
         endcase
      end
      u_dfd_ctrl_model.run(f, a, 2 + int'(rv[14:12]), x, q, r);
      if (ex && f == dfd_pkg::F_CLR_EN) lam_en = 1'b0;
      if (ex && f == dfd_pkg::F_SET_EN) lam_en = 1'b1;
      if (ex && (f == dfd_pkg::F_READ || f == dfd_pkg::F_READ_CONV)) pend[a[0]] = 1'b0;
      if (!off) irq_m = irq_m | {1'b0, es != 2'h0, !ex, ex};
      chk(x, ex);
      chk(q, eq);
      chk(r, er);
      chk(seen, es);
      chk(dw_lam_o, lam_en & (|pend));
   endtask

   task automatic wrap_up();
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [31:0] q;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rchk(dfd_pkg::REG_CTRL, 32'h00000000, 32'hFFFFFFFF);
      rchk(dfd_pkg::REG_IRQ_EN, 32'h00000000, 32'hFFFFFFFF);
      wb(1'b1, 8'hFC, 32'hFFFFFFFF, q);
      rchk(8'hFC, 32'h00000000, 32'hFFFFFFFF);
      // two sweeps so the lam test also runs with the enable set
      for (int s = 0; s < 2; s++)
         for (int f = 0; f < 32; f++)
            for (int a = 0; a < 16; a++)
               do_cmd(5'(f), 4'(a), 1'b0);
      wb(1'b1, dfd_pkg::REG_CTRL, 32'h00000001, q);
      do_cmd(dfd_pkg::F_CONV, dfd_pkg::A_BOTH, 1'b1);
      wb(1'b1, dfd_pkg::REG_CTRL, 32'h00000000, q);
      rchk(dfd_pkg::REG_STAT, {31'h0, lam_en}, 32'h00000001);
      u_dfd_ctrl_model.pulse_z();
      lam_en = 1'b0;
      pend = 2'h0;
      irq_m[dfd_pkg::IRQ_Z] = 1'b1;
      rchk(dfd_pkg::REG_STAT, {24'h0, 2'h0, adc_busy_i, 4'h0}, 32'hFFFFFFFF);
      do_cmd(dfd_pkg::F_TEST_LAM, dfd_pkg::A_LAM_ALT, 1'b0);
      rchk(dfd_pkg::REG_LAST, {22'h0, 1'b1, dfd_pkg::F_TEST_LAM, dfd_pkg::A_LAM_ALT},
         32'hFFFFFFFF);
      chk(irq_o, 32'h00000000);
      rchk(dfd_pkg::REG_IRQ_STAT, {28'h0, irq_m}, 32'hFFFFFFFF);
      wb(1'b1, dfd_pkg::REG_IRQ_EN, 32'h0000000F, q);
      chk(irq_o, {31'h0, |irq_m});
      wb(1'b1, dfd_pkg::REG_IRQ_CLR, 32'h0000000F, q);
      rchk(dfd_pkg::REG_IRQ_STAT, 32'h00000000, 32'hFFFFFFFF);
      chk(irq_o, 32'h00000000);
      wrap_up();
   end
endmodule
`default_nettype wire
